// *** core/gpp_port_io.sv ***
// general purpose port logic for two 8-bit ports with drive mode registers and a port 0 skip register
`timescale 1ns/1ps
module gpp_port_io
	import gpp_pkg::*;
(
	input  wire logic       CORE_CLK,
	input  wire logic       RST,
	// special function register access from the core
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic [7:0] SFR_WDATA,
	input  wire logic       SFR_WE,
	input  wire logic       SFR_RE,
	input  wire logic       SFR_BIT_EN,
	input  wire logic [2:0] SFR_BIT_SEL,
	input  wire logic       SFR_RMW,
	output logic      [7:0] SFR_RDATA,
	// per-pin configuration to and from neighbouring logic
	input  wire logic [7:0] PORT0_INPUT_MODE,
	input  wire logic [7:0] PORT1_INPUT_MODE,
	input  wire logic [7:0] PORT0_XBAR_CLAIM,
	input  wire logic [7:0] PORT1_XBAR_CLAIM,
	input  wire logic [7:0] PORT0_TWO_WIRE,
	input  wire logic [7:0] PORT1_TWO_WIRE,
	output logic      [7:0] PORT0_CROSSBAR_SKIP,
	// pins
	input  wire logic [7:0] PORT0_PIN_IN,
	output logic      [7:0] PORT0_PIN_OUT,
	output logic      [7:0] PORT0_PIN_OE,
	input  wire logic [7:0] PORT1_PIN_IN,
	output logic      [7:0] PORT1_PIN_OUT,
	output logic      [7:0] PORT1_PIN_OE
);

	gpp_state_t state_reg;
	gpp_state_t state_next;
	logic [7:0] pins0_sync;
	logic [7:0] pins1_sync;

	gpp_sync u_sync0 (
		.clk      (CORE_CLK),
		.rst      (RST),
		.async_in (PORT0_PIN_IN),
		.sync_out (pins0_sync)
	);

	gpp_sync u_sync1 (
		.clk      (CORE_CLK),
		.rst      (RST),
		.async_in (PORT1_PIN_IN),
		.sync_out (pins1_sync)
	);

	// output enable per pin: low latch sinks unless analog or claimed, high latch sources only in push-pull
	function automatic logic [7:0] drive_enable(
		input logic [7:0] latch,
		input logic [7:0] drive_mode,
		input logic [7:0] input_mode,
		input logic [7:0] claim,
		input logic [7:0] two_wire
	);
		logic [7:0] digital;
		logic [7:0] push_pull;
		// analog pins never drive, so the drive mode bit cannot matter there
		digital   = input_mode & ~GPP_MODE_ANALOG;
		// two-wire pins forced open-drain regardless of drive mode
		push_pull = (drive_mode ^ GPP_DRIVE_OPEN) & ~two_wire;
		// claimed pins belong to the crossbar peripheral, not to the latch
		return digital & ~claim & (~latch | push_pull);
	endfunction : drive_enable

	// value seen by a read: latch under read-modify-write, else pin level
	function automatic logic [7:0] port_read(
		input logic       rmw,
		input logic [7:0] latch,
		input logic [7:0] pins,
		input logic [7:0] input_mode
	);
		// the core flags rmw for anl orl xrl jbc cpl inc dec djnz and bit moves
		if (rmw) begin
			return latch;
		end
		// analog pins read 0; crossbar claim does not hide the pin level
		return pins & input_mode;
	endfunction : port_read

	// byte write or single-bit write into an 8-bit register
	function automatic logic [7:0] merge_write(
		input logic [7:0] old_value,
		input logic [7:0] wdata,
		input logic       bit_en,
		input logic [2:0] bit_sel
	);
		logic [7:0] result;
		result = old_value;
		if (bit_en) begin
			result[bit_sel] = wdata[GPP_BIT_VALUE_POS];
		end else begin
			result = wdata;
		end
		return result;
	endfunction : merge_write

	always_comb begin
		logic [7:0] byte_value;
		logic       bit_ok;
		byte_value = GPP_UNMAPPED_READ;
		bit_ok     = (SFR_ADDR == GPP_ADDR_PORT0_LATCH) || (SFR_ADDR == GPP_ADDR_PORT1_LATCH);
		state_next = state_reg;

		// register writes; bit access only reaches the bit-addressable port registers
		if (SFR_WE && (!SFR_BIT_EN || bit_ok)) begin
			case (SFR_ADDR)
				GPP_ADDR_PORT0_LATCH: begin
					state_next.port0.latch = merge_write(state_reg.port0.latch, SFR_WDATA,
						SFR_BIT_EN, SFR_BIT_SEL);
				end
				GPP_ADDR_PORT1_LATCH: begin
					state_next.port1.latch = merge_write(state_reg.port1.latch, SFR_WDATA,
						SFR_BIT_EN, SFR_BIT_SEL);
				end
				GPP_ADDR_PORT0_DRIVE_MODE: begin
					state_next.port0.drive_mode = SFR_WDATA;
				end
				GPP_ADDR_PORT1_DRIVE_MODE: begin
					state_next.port1.drive_mode = SFR_WDATA;
				end
				GPP_ADDR_PORT0_SKIP: begin
					state_next.skip0 = SFR_WDATA;
				end
				default: begin
				end
			endcase
		end

		// register reads, answered from a flop one cycle later
		case (SFR_ADDR)
			GPP_ADDR_PORT0_LATCH: begin
				byte_value = port_read(SFR_RMW, state_reg.port0.latch, pins0_sync, PORT0_INPUT_MODE);
			end
			GPP_ADDR_PORT1_LATCH: begin
				byte_value = port_read(SFR_RMW, state_reg.port1.latch, pins1_sync, PORT1_INPUT_MODE);
			end
			GPP_ADDR_PORT0_DRIVE_MODE: begin
				byte_value = state_reg.port0.drive_mode;
			end
			GPP_ADDR_PORT1_DRIVE_MODE: begin
				byte_value = state_reg.port1.drive_mode;
			end
			GPP_ADDR_PORT0_SKIP: begin
				byte_value = state_reg.skip0;
			end
			default: begin
				byte_value = GPP_UNMAPPED_READ;
			end
		endcase
		if (SFR_RE) begin
			if (SFR_BIT_EN) begin
				state_next.rdata = {7'h00, byte_value[SFR_BIT_SEL]};
			end else begin
				state_next.rdata = byte_value;
			end
		end

		// pin drive follows the new latch so outputs change with the write
		state_next.port0.pin_out = state_next.port0.latch;
		state_next.port1.pin_out = state_next.port1.latch;
		state_next.port0.pin_oe  = drive_enable(state_next.port0.latch, state_next.port0.drive_mode,
			PORT0_INPUT_MODE, PORT0_XBAR_CLAIM, PORT0_TWO_WIRE);
		state_next.port1.pin_oe  = drive_enable(state_next.port1.latch, state_next.port1.drive_mode,
			PORT1_INPUT_MODE, PORT1_XBAR_CLAIM, PORT1_TWO_WIRE);
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_reg.port0.latch      <= GPP_RST_LATCH;
			state_reg.port0.drive_mode <= GPP_RST_DRIVE_MODE;
			state_reg.port0.pin_out    <= GPP_RST_LATCH;
			state_reg.port0.pin_oe     <= 8'h00;
			state_reg.port1.latch      <= GPP_RST_LATCH;
			state_reg.port1.drive_mode <= GPP_RST_DRIVE_MODE;
			state_reg.port1.pin_out    <= GPP_RST_LATCH;
			state_reg.port1.pin_oe     <= 8'h00;
			state_reg.skip0            <= GPP_RST_SKIP;
			state_reg.rdata            <= GPP_RST_RDATA;
		end else begin
			state_reg <= state_next;
		end
	end

	assign SFR_RDATA           = state_reg.rdata;
	assign PORT0_CROSSBAR_SKIP = state_reg.skip0;
	assign PORT0_PIN_OUT       = state_reg.port0.pin_out;
	assign PORT0_PIN_OE        = state_reg.port0.pin_oe;
	assign PORT1_PIN_OUT       = state_reg.port1.pin_out;
	assign PORT1_PIN_OE        = state_reg.port1.pin_oe;

endmodule : gpp_port_io

// *** core/gpp_pkg.sv ***
// shared constants and state types for the general purpose port block
package gpp_pkg;

	localparam logic [7:0] GPP_ADDR_PORT0_LATCH      = 8'h80;
	localparam logic [7:0] GPP_ADDR_PORT1_LATCH      = 8'h90;
	localparam logic [7:0] GPP_ADDR_PORT0_DRIVE_MODE = 8'ha4;
	localparam logic [7:0] GPP_ADDR_PORT1_DRIVE_MODE = 8'ha5;
	localparam logic [7:0] GPP_ADDR_PORT0_SKIP       = 8'hd4;

	localparam logic [7:0] GPP_RST_LATCH      = 8'hff;
	localparam logic [7:0] GPP_RST_DRIVE_MODE = 8'h00;
	localparam logic [7:0] GPP_RST_SKIP       = 8'h00;
	localparam logic [7:0] GPP_RST_RDATA      = 8'h00;
	localparam logic [7:0] GPP_UNMAPPED_READ  = 8'h00;

	localparam logic [7:0] GPP_MODE_ANALOG    = 8'h00;
	localparam logic [7:0] GPP_DRIVE_OPEN     = 8'h00;
	localparam int         GPP_BIT_VALUE_POS  = 0;

	// one port: pin value, enable and the latch it comes from
	typedef struct packed {
		logic [7:0] latch;
		logic [7:0] drive_mode;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
	} gpp_port_t;

	typedef struct packed {
		gpp_port_t  port0;
		gpp_port_t  port1;
		logic [7:0] skip0;
		logic [7:0] rdata;
	} gpp_state_t;

	typedef struct packed {
		logic [7:0] stage1;
		logic [7:0] stage2;
	} gpp_sync_t;

endpackage : gpp_pkg

// *** core/gpp_sync.sv ***
// two-flop synchroniser for one port's eight pin levels
`timescale 1ns/1ps
module gpp_sync
	import gpp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] async_in,
	output logic      [7:0] sync_out
);

	gpp_sync_t state_reg;
	gpp_sync_t state_next;

	// stage1 feeds stage2 only; nothing else looks at it
	always_comb begin
		state_next        = state_reg;
		state_next.stage1 = async_in;
		state_next.stage2 = state_reg.stage1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_out = state_reg.stage2;

endmodule : gpp_sync

// *** sim/gpp_sva.sv ***
// assertion checker for the general purpose port block
`timescale 1ns/1ps
module gpp_sva
	import gpp_pkg::*;
(
	input wire logic       CORE_CLK,
	input wire logic       RST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic       SFR_WE,
	input wire logic       SFR_RE,
	input wire logic       SFR_BIT_EN,
	input wire logic [2:0] SFR_BIT_SEL,
	input wire logic       SFR_RMW,
	input wire logic [7:0] SFR_RDATA,
	input wire logic [7:0] PORT0_INPUT_MODE,
	input wire logic [7:0] PORT0_XBAR_CLAIM,
	input wire logic [7:0] PORT1_TWO_WIRE,
	input wire logic [7:0] PORT0_CROSSBAR_SKIP,
	input wire logic [7:0] PORT0_PIN_OUT,
	input wire logic [7:0] PORT0_PIN_OE,
	input wire logic [7:0] PORT1_PIN_OUT,
	input wire logic [7:0] PORT1_PIN_OE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	rmw_latch_a: assert property (SFR_RE && SFR_RMW && !SFR_BIT_EN && SFR_ADDR == 8'h80
		|=> SFR_RDATA == $past(PORT0_PIN_OUT)) else $error("rmw read not from latch");
	rmw_bit_a: assert property (SFR_RE && SFR_RMW && SFR_BIT_EN && SFR_ADDR == 8'h90
		|=> SFR_RDATA == (($past(PORT1_PIN_OUT) >> $past(SFR_BIT_SEL)) & 8'h01)) else $error("bad rmw bit read");
	byte_write_a: assert property (SFR_WE && !SFR_BIT_EN && SFR_ADDR == 8'h80
		|=> PORT0_PIN_OUT == $past(SFR_WDATA)) else $error("latch write lost");
	latch_hold_a: assert property (!(SFR_WE && SFR_ADDR == 8'h80) |=> $stable(PORT0_PIN_OUT))
		else $error("latch changed unwritten");
	bit_write_a: assert property (SFR_WE && SFR_BIT_EN && SFR_ADDR == 8'h90 |=> PORT1_PIN_OUT ==
		(($past(PORT1_PIN_OUT) & ~(8'h01 << $past(SFR_BIT_SEL))) | (($past(SFR_WDATA) & 8'h01) << $past(SFR_BIT_SEL))))
		else $error("bad bit write");
	analog_off_a: assert property ((PORT0_PIN_OE & ~($past(PORT0_INPUT_MODE) & ~$past(PORT0_XBAR_CLAIM))) == 8'h00)
		else $error("analog or claimed pin driven");
	low_drive_a: assert property ((~PORT0_PIN_OUT & ~PORT0_PIN_OE & $past(PORT0_INPUT_MODE)
		& ~$past(PORT0_XBAR_CLAIM)) == 8'h00) else $error("low latch not driven");
	two_wire_a: assert property ((PORT1_PIN_OE & PORT1_PIN_OUT & $past(PORT1_TWO_WIRE)) == 8'h00)
		else $error("two-wire pin driven high");
	skip_write_a: assert property (SFR_WE && !SFR_BIT_EN && SFR_ADDR == 8'hd4
		|=> PORT0_CROSSBAR_SKIP == $past(SFR_WDATA)) else $error("skip write lost");
	cover property (SFR_RE && SFR_RMW && SFR_BIT_EN);
	cover property (SFR_WE && SFR_BIT_EN);
	cover property (PORT1_PIN_OE == 8'hfc);
endmodule : gpp_sva

bind gpp_port_io gpp_sva gpp_sva_i (.*);

// *** sim/gpp_board.sv ***
// board side of one port: external level on pins the block leaves floating
`timescale 1ns/1ps
module gpp_board (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_level,
	output logic      [7:0] pin_level
);
	// undriven pins show the board's level, never the last driven value
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gpp_board

// *** sim/testbench.sv ***
// self-checking testbench for the general purpose port block
`timescale 1ns/1ps
module testbench;
	logic       CORE_CLK, RST, SFR_WE, SFR_RE, SFR_BIT_EN, SFR_RMW;
	logic [2:0] SFR_BIT_SEL;
	logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, PORT0_INPUT_MODE, PORT1_INPUT_MODE, ext0, ext1;
	logic [7:0] PORT0_XBAR_CLAIM, PORT1_XBAR_CLAIM, PORT0_TWO_WIRE, PORT1_TWO_WIRE, PORT0_CROSSBAR_SKIP;
	logic [7:0] PORT0_PIN_IN, PORT0_PIN_OUT, PORT0_PIN_OE, PORT1_PIN_IN, PORT1_PIN_OUT, PORT1_PIN_OE;
	int         errors = 0;
	int         checked = 0;
	gpp_port_io gpp_port_io_i (.*);
	gpp_board gpp_board_i (.pin_out(PORT0_PIN_OUT), .pin_oe(PORT0_PIN_OE), .ext_level(ext0), .pin_level(PORT0_PIN_IN));
	gpp_board gpp_board1_i (.pin_out(PORT1_PIN_OUT), .pin_oe(PORT1_PIN_OE), .ext_level(ext1), .pin_level(PORT1_PIN_IN));
	task automatic give_verdict();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0, input logic [2:0] s = 3'h0);
		@(posedge CORE_CLK);
		{SFR_ADDR, SFR_WDATA, SFR_BIT_EN, SFR_BIT_SEL, SFR_WE} <= {a, d, b, s, 1'b1};
		@(posedge CORE_CLK);
		SFR_WE <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic m, input logic b, input logic [2:0] s, input logic [7:0] e);
		@(posedge CORE_CLK);
		{SFR_ADDR, SFR_RMW, SFR_BIT_EN, SFR_BIT_SEL, SFR_RE} <= {a, m, b, s, 1'b1};
		@(posedge CORE_CLK);
		SFR_RE <= 1'b0;
		@(negedge CORE_CLK);
		chk(SFR_RDATA, e);
	endtask : rd
	task automatic settle();
		repeat (4) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
	endtask : settle
	initial begin
		CORE_CLK = 1'b0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	initial begin
		repeat (2000) @(posedge CORE_CLK);
		errors++;
		give_verdict();
	end
	initial begin
		RST = 1'b1;
		{SFR_WE, SFR_RE, SFR_BIT_EN, SFR_RMW, SFR_BIT_SEL, SFR_ADDR, SFR_WDATA} = '0;
		{PORT0_XBAR_CLAIM, PORT1_XBAR_CLAIM, PORT0_TWO_WIRE, PORT1_TWO_WIRE, ext0} = '0;
		{PORT0_INPUT_MODE, PORT1_INPUT_MODE, ext1} = '1;
		repeat (6) @(posedge CORE_CLK);
		RST <= 1'b0;
		settle();
		rd(8'ha4, 1'b0, 1'b0, 3'h0, 8'h00);
		rd(8'hd4, 1'b0, 1'b0, 3'h0, 8'h00);
		wr(8'ha4, 8'h0f);
		wr(8'h80, 8'h5a);
		settle();
		rd(8'h80, 1'b1, 1'b0, 3'h0, 8'h5a);
		rd(8'h80, 1'b0, 1'b0, 3'h0, 8'h0a);
		@(posedge CORE_CLK);
		PORT0_INPUT_MODE <= 8'hf0;
		ext0 <= 8'hff;
		settle();
		chk(PORT0_PIN_OE, 8'ha0);
		chk(PORT0_PIN_OUT, 8'h5a);
		rd(8'h80, 1'b0, 1'b0, 3'h0, 8'h50);
		@(posedge CORE_CLK);
		PORT0_XBAR_CLAIM <= 8'hc0;
		settle();
		chk(PORT0_PIN_OE, 8'h20);
		rd(8'h80, 1'b0, 1'b0, 3'h0, 8'hd0);
		rd(8'h80, 1'b1, 1'b0, 3'h0, 8'h5a);
		@(posedge CORE_CLK);
		PORT1_TWO_WIRE <= 8'h03;
		wr(8'ha5, 8'hff);
		wr(8'h90, 8'h0f);
		settle();
		chk(PORT1_PIN_OE, 8'hfc);
		wr(8'h90, 8'h01, 1'b1, 3'h7);
		wr(8'h90, 8'h00, 1'b1, 3'h0);
		rd(8'h90, 1'b1, 1'b1, 3'h7, 8'h01);
		rd(8'h90, 1'b1, 1'b0, 3'h0, 8'h8e);
		wr(8'ha5, 8'h00, 1'b1, 3'h0);
		rd(8'ha5, 1'b0, 1'b0, 3'h0, 8'hff);
		settle();
		rd(8'h90, 1'b0, 1'b1, 3'h7, 8'h01);
		wr(8'hd4, 8'ha5);
		// skip output lands at the write edge; look once it has settled
		@(negedge CORE_CLK);
		chk(PORT0_CROSSBAR_SKIP, 8'ha5);
		wr(8'h00, 8'h33);
		rd(8'h00, 1'b0, 1'b0, 3'h0, 8'h00);
		@(posedge CORE_CLK);
		RST <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		RST <= 1'b0;
		rd(8'h80, 1'b1, 1'b0, 3'h0, 8'hff);
		give_verdict();
	end
endmodule : testbench
